// ### core/crg_gate.sv
// Behaviour
// - slow input low selects reduced chipset rate; high selects normal rate
// - reduced chipset rate is configurable and defaults to 80 MHz
// - selected pairs four and five run on request low, both low otherwise
// - selected pair three runs on request low, true and complement low otherwise
// - selected pair two runs on request low, true and complement low otherwise
// - selected pair one runs on request low, true and complement low otherwise
// - power down input low stops all reference and chipset pairs; high restores operation
// - output and mode controls arrive from the two-wire management interface
`timescale 1ns/1ps
`default_nettype none
module crg_gate
  import crg_pkg::*;
(
  input  wire logic              i_core_clk,  // core clock, 250 MHz
  input  wire logic              i_arst_n,    // async reset
  input  wire crg_pins_t         i_pins,      // raw pin levels
  input  wire crg_ctrl_t         i_ctrl,      // management controls
  input  wire logic              i_ref_clk,   // synthesized reference phase
  input  wire logic              i_chip_clk,  // synthesized chipset phase
  output logic [NUM_REF-1:0]     o_run,       // per pair running
  output crg_pair_t [NUM_REF-1:0] o_ref,      // gated reference pairs
  output crg_pair_t              o_chip,      // chipset reference pair
  output logic                   o_chip_slow, // chipset at reduced rate
  output logic [7:0]             o_chip_mhz   // chipset rate in MHz
);

  // two-stage synchronisers for pin levels
  crg_pins_t pin_s1_q;
  crg_pins_t pin_s2_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
    end else begin
      pin_s1_q <= i_pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  // request pin serving each pair: four and five share one
  function automatic int unsigned req_of(input int unsigned k);
    return (k >= 3) ? 3 : k;
  endfunction : req_of

  logic [NUM_REF-1:0] run_d;
  logic [NUM_REF-1:0] run_q;
  crg_pair_t [NUM_REF-1:0] ref_d;
  crg_pair_t [NUM_REF-1:0] ref_q;

  genvar g;
  generate
    for (g = 0; g < NUM_REF; g++) begin : g_pair
      always_comb begin
        run_d[g] = pin_s2_q.pwr_n && i_ctrl.oe[g];
        if (i_ctrl.req_sel[g] && pin_s2_q.req_n[req_of(g)]) begin
          run_d[g] = 1'b0;
        end
        // unselected pairs skip the request term above
        ref_d[g].t = run_d[g] & i_ref_clk;
        ref_d[g].c = run_d[g] & ~i_ref_clk;
      end
    end
  endgenerate

  logic       chip_run_d;
  logic       slow_d;
  logic       slow_q;
  logic [7:0] mhz_d;
  logic [7:0] mhz_q;
  crg_pair_t  chip_d;
  crg_pair_t  chip_q;

  always_comb begin
    chip_run_d = pin_s2_q.pwr_n;
    slow_d     = ~pin_s2_q.slow_n;
    mhz_d      = slow_d ? i_ctrl.slow_mhz
                        : 8'(CHIP_NORM_MHZ);
    chip_d.t   = chip_run_d & i_chip_clk;
    chip_d.c   = chip_run_d & ~i_chip_clk;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_q  <= '0;
      ref_q  <= '0;
      slow_q <= 1'b0;
      mhz_q  <= 8'(CHIP_NORM_MHZ);
      chip_q <= '0;
    end else begin
      run_q  <= run_d;
      ref_q  <= ref_d;
      slow_q <= slow_d;
      mhz_q  <= mhz_d;
      chip_q <= chip_d;
    end
  end

  assign o_run       = run_q;
  assign o_ref       = ref_q;
  assign o_chip      = chip_q;
  assign o_chip_slow = slow_q;
  assign o_chip_mhz  = mhz_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  // a pin level needs two synchroniser edges and the output register,
  // so it is held over four samples before the output is judged
  sequence s_pwr_down;
    !i_pins.pwr_n [*4];
  endsequence

  sequence s_pwr_up;
    i_pins.pwr_n [*4];
  endsequence

  sequence s_slow_held;
    !i_pins.slow_n [*4];
  endsequence

  sequence s_norm_held;
    i_pins.slow_n [*4];
  endsequence

  sequence s_parked(sel, rq_n);
    (sel && rq_n) [*4];
  endsequence

  sequence s_wanted(sel, rq_n, en);
    (sel && !rq_n && en && i_pins.pwr_n) [*4];
  endsequence

  sequence s_free(sel, en);
    (!sel && en && i_pins.pwr_n) [*4];
  endsequence

  pwr_stop_a: assert property (
      s_pwr_down |-> o_run == '0 && o_ref == '0 && o_chip == '0)
    else $error("outputs not stopped in power down");

  pwr_run_a: assert property (
      s_pwr_up |-> o_chip.t == $past(i_chip_clk)
      && o_chip.c == !$past(i_chip_clk))
    else $error("chipset pair not running");

  slow_rate_a: assert property (
      s_slow_held |-> o_chip_slow && o_chip_mhz == $past(i_ctrl.slow_mhz))
    else $error("chipset rate not reduced");

  norm_rate_a: assert property (
      s_norm_held |-> !o_chip_slow && o_chip_mhz == 8'(CHIP_NORM_MHZ))
    else $error("chipset rate not normal");

  req45_off_a: assert property (
      s_parked(i_ctrl.req_sel[4], i_pins.req_n[3])
      |-> !o_run[4] && o_ref[4] == '0)
    else $error("pair five runs while parked");

  req4_off_a: assert property (
      s_parked(i_ctrl.req_sel[3], i_pins.req_n[3])
      |-> !o_run[3] && o_ref[3] == '0)
    else $error("pair four runs while parked");

  req3_off_a: assert property (
      s_parked(i_ctrl.req_sel[2], i_pins.req_n[2])
      |-> !o_run[2] && o_ref[2] == '0)
    else $error("pair three runs while parked");

  req2_off_a: assert property (
      s_parked(i_ctrl.req_sel[1], i_pins.req_n[1])
      |-> !o_run[1] && o_ref[1] == '0)
    else $error("pair two runs while parked");

  req1_off_a: assert property (
      s_parked(i_ctrl.req_sel[0], i_pins.req_n[0])
      |-> !o_run[0] && o_ref[0] == '0)
    else $error("pair one runs while parked");

  req45_on_a: assert property (
      s_wanted(i_ctrl.req_sel[4], i_pins.req_n[3], i_ctrl.oe[4])
      |-> o_run[4])
    else $error("pair five parked while wanted");

  req4_on_a: assert property (
      s_wanted(i_ctrl.req_sel[3], i_pins.req_n[3], i_ctrl.oe[3])
      |-> o_run[3])
    else $error("pair four parked while wanted");

  req3_on_a: assert property (
      s_wanted(i_ctrl.req_sel[2], i_pins.req_n[2], i_ctrl.oe[2])
      |-> o_run[2])
    else $error("pair three parked while wanted");

  req2_on_a: assert property (
      s_wanted(i_ctrl.req_sel[1], i_pins.req_n[1], i_ctrl.oe[1])
      |-> o_run[1])
    else $error("pair two parked while wanted");

  req1_on_a: assert property (
      s_wanted(i_ctrl.req_sel[0], i_pins.req_n[0], i_ctrl.oe[0])
      |-> o_run[0])
    else $error("pair one parked while wanted");

  free_run_a: assert property (
      s_free(i_ctrl.req_sel[0], i_ctrl.oe[0]) |-> o_run[0])
    else $error("free pair stopped by request");

  free45_run_a: assert property (
      s_free(i_ctrl.req_sel[4], i_ctrl.oe[4]) |-> o_run[4])
    else $error("free shared pair stopped by request");

  oe_stop_a: assert property (
      (o_run & ~$past(i_ctrl.oe)) == '0)
    else $error("disabled pair running");

  ref1_phase_a: assert property (
      o_ref[0].t == (o_run[0] && $past(i_ref_clk))
      && o_ref[0].c == (o_run[0] && !$past(i_ref_clk)))
    else $error("pair one phase wrong");

  ref2_phase_a: assert property (
      o_ref[1].t == (o_run[1] && $past(i_ref_clk))
      && o_ref[1].c == (o_run[1] && !$past(i_ref_clk)))
    else $error("pair two phase wrong");

  ref3_phase_a: assert property (
      o_ref[2].t == (o_run[2] && $past(i_ref_clk))
      && o_ref[2].c == (o_run[2] && !$past(i_ref_clk)))
    else $error("pair three phase wrong");

  ref4_phase_a: assert property (
      o_ref[3].t == (o_run[3] && $past(i_ref_clk))
      && o_ref[3].c == (o_run[3] && !$past(i_ref_clk)))
    else $error("pair four phase wrong");

  ref5_phase_a: assert property (
      o_ref[4].t == (o_run[4] && $past(i_ref_clk))
      && o_ref[4].c == (o_run[4] && !$past(i_ref_clk)))
    else $error("pair five phase wrong");

endmodule : crg_gate
`default_nettype wire

// ### core/crg_pkg.sv
package crg_pkg;

  // reference pairs with a request pin: one, two, three, and four/five
  localparam int unsigned NUM_REQ = 4;
  localparam int unsigned NUM_REF = 5;

  // normal chipset reference rate and default slow rate in MHz
  localparam int unsigned CHIP_NORM_MHZ = 100;
  localparam int unsigned CHIP_SLOW_MHZ = 80;

  // reset values
  localparam logic [7:0] SLOW_MHZ_RST = CHIP_SLOW_MHZ[7:0];
  localparam logic [NUM_REF-1:0] REQ_SEL_RST = 5'h00;
  localparam logic [NUM_REF-1:0] OE_RST = 5'h1f;

  // differential output pair, true and complement
  typedef struct packed {
    logic t;
    logic c;
  } crg_pair_t;

  // pin inputs from the requesting parties, all active low
  typedef struct packed {
    logic slow_n;
    logic pwr_n;
    logic [NUM_REQ-1:0] req_n;
  } crg_pins_t;

  // management controls, held by the two-wire management logic
  typedef struct packed {
    logic [NUM_REF-1:0] req_sel;
    logic [NUM_REF-1:0] oe;
    logic [7:0] slow_mhz;
  } crg_ctrl_t;

endpackage : crg_pkg

// ### tb/clock_request_slowdown_gating_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clock_request_slowdown_gating_tb;
  import crg_pkg::*;
  typedef logic [25:0] crg_snap_t;
  logic            clk = 1'h0, rst_n = 1'h0, rclk = 1'h0, cclk = 1'h0;
  logic            slow = 1'h0, pwr = 1'h1, chk = 1'h0, sn;
  logic      [3:0] want = 4'h0, rq;
  crg_ctrl_t       ctrl = '{req_sel: REQ_SEL_RST, oe: OE_RST,
                            slow_mhz: SLOW_MHZ_RST};
  logic      [4:0] run;
  crg_pair_t [4:0] pair_o;
  crg_pair_t       chip;
  logic            cslow;
  logic      [7:0] mhz;
  logic     [15:0] r = 16'h0043, s;
  crg_snap_t       q[$];
  crg_snap_t       exp_v;
  wire crg_snap_t  seen = {run, pair_o, chip, cslow, mhz};
  int              num_errors = 0, checks = 0;
  wire crg_pins_t  pins = {sn, pwr, rq};
  always #2 clk = ~clk;
  crg_req_model req (.i_clk(clk), .i_want(want), .i_slow(slow),
    .o_req_n(rq), .o_slow_n(sn));
  crg_gate dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_pins(pins),
    .i_ctrl(ctrl), .i_ref_clk(rclk), .i_chip_clk(cclk), .o_run(run),
    .o_ref(pair_o), .o_chip(chip), .o_chip_slow(cslow), .o_chip_mhz(mhz));
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic crg_snap_t exp_f();
    logic [4:0] rn, go;
    logic [9:0] p;
    rn = ~{want[3], want};  // pairs four and five share one pin
    go = {5{pwr}} & ctrl.oe & ~(ctrl.req_sel & rn);
    for (int k = 0; k < 5; k++) p[2*k+:2] = {go[k] & rclk, go[k] & ~rclk};
    return {go, p, pwr ? {cclk, ~cclk} : 2'h0, slow,
            slow ? ctrl.slow_mhz : CHIP_NORM_MHZ[7:0]};
  endfunction : exp_f
  task automatic cmp(string n, crg_snap_t e, crg_snap_t g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task automatic test_done();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  always @(negedge clk) if (chk === 1'h1) begin
    exp_v = q.pop_front();
    cmp("outputs", exp_v, seen);
  end
  initial begin
    repeat (5) @(posedge clk);
    q.push_back({18'h0, CHIP_NORM_MHZ[7:0]});
    chk <= 1'h1;
    @(posedge clk);
    chk <= 1'h0;
    rst_n <= 1'h1;
    for (int i = 0; i < 60; i++) begin
      r = lfsr(r);
      s = lfsr(r);
      r = s;
      @(posedge clk);
      want <= r[3:0];
      slow <= r[4];
      pwr <= r[5] | r[6];
      rclk <= r[7];
      cclk <= r[8];
      ctrl <= '{req_sel: r[13:9], oe: s[2:0] | r[15:11],
                slow_mhz: (i == 0) ? SLOW_MHZ_RST : {r[15:9], s[0]}};
      repeat (5) @(posedge clk);
      q.push_back(exp_f());
      chk <= 1'h1;
      @(posedge clk);
      chk <= 1'h0;
    end
    for (int k = 0; k < 10 && q.size() > 0; k++) @(posedge clk);
    if (q.size() > 0) num_errors++;
    test_done();
  end
endmodule : clock_request_slowdown_gating_tb
`default_nettype wire

// ### tb/crg_req_model.sv
`timescale 1ns/1ps
`default_nettype none
module crg_req_model (
  input  wire logic       i_clk,    // core clock
  input  wire logic [3:0] i_want,   // pairs wanted running
  input  wire logic       i_slow,   // ask for reduced rate
  output logic      [3:0] o_req_n,  // request pins
  output logic            o_slow_n  // slow pin
);
  // pins move just after an edge and hold as levels
  always @(posedge i_clk) begin
    o_req_n  <= ~i_want;
    o_slow_n <= ~i_slow;
  end
endmodule : crg_req_model
`default_nettype wire
